// [tascr_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tascr_top #(
  parameter int CONV_CYCLES = tascr_pkg::CONV_CYC,
  parameter int TICK_CYCLES = tascr_pkg::TICK_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic WR_I,
  input wire logic [7:0] PTR_I,
  input wire logic [15:0] WDATA_I,
  output logic [15:0] RDATA_O,
  input wire logic [15:0] TEMP_I,
  input wire logic [15:0] LIMIT2_I,
  input wire logic [15:0] HYST_I,
  input wire logic [7:0] OPEN_DET_I,
  output logic [3:0] CHAN_O,
  output logic RESULT_STORE_O,
  output logic SECOND_ALERT_PIN_O
);
  // refuse counts the sequencer cannot serve
  if (CONV_CYCLES < 2 || TICK_CYCLES < 1) begin : g_bad_counts
    $error("cycle counts too small");
  end
  // ************************************************************
  // input synchronisers for open detectors
  // ************************************************************
  logic [7:0] open_s1_r;
  logic [7:0] open_s2_r;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      open_s1_r <= 8'h00;
      open_s2_r <= 8'h00;
    end else begin
      open_s1_r <= OPEN_DET_I;
      open_s2_r <= open_s1_r;
    end
  end
  // ************************************************************
  // configuration register
  // ************************************************************
  logic [15:0] cfg_r;
  logic [15:0] cfg_nxt;
  logic busy;
  logic pass_done;
  logic cfg_wr;
  logic [8:0] chan_en;
  logic sd;
  logic os;
  logic [2:0] rate;
  assign cfg_wr = WR_I && PTR_I == tascr_pkg::PTR_CONFIG;
  assign chan_en = {cfg_r[15:tascr_pkg::CFG_REN_LSB],
    cfg_r[tascr_pkg::CFG_LEN_BIT]};
  assign sd = cfg_r[tascr_pkg::CFG_SD_BIT];
  assign os = cfg_r[tascr_pkg::CFG_OS_BIT];
  assign rate = cfg_r[tascr_pkg::CFG_CR_LSB +: 3];
  // write mask, busy merge and one-shot self clear
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_wr) begin
      cfg_nxt = WDATA_I & tascr_pkg::CFG_WRITE_MASK;
    end else if (pass_done && os) begin
      cfg_nxt[tascr_pkg::CFG_OS_BIT] = 1'b0;
    end
    cfg_nxt[tascr_pkg::CFG_BUSY_BIT] = busy;
  end
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_r <= tascr_pkg::CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end
  // ************************************************************
  // channel sequencer
  // ************************************************************
  tascr_pkg::tascr_state_e state_r;
  tascr_pkg::tascr_state_e state_nxt;
  logic [3:0] chan_r;
  logic [31:0] cnt_r;
  logic [31:0] tick_r;
  logic [6:0] idle_r;
  logic conv_end;
  logic run;
  logic [3:0] next_chan;
  logic last_chan;
  logic [6:0] idle_ticks;
  logic [4:0] after_cur;
  logic [4:0] after_none;
  logic [3:0] first_chan;
  logic pass_gap;
  // slowest rate, 16 s counted in quarter-second ticks
  localparam logic [6:0] IDLE_TICKS_MAX = 7'h40;
  tascr_if res_if ();
  // next enabled channel above a given one, 5'h10 when there is none
  function automatic logic [4:0] find_next(input logic [3:0] c,
                                          input logic [8:0] en);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 8; i >= 0; i--) begin
      if (i > c && en[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : find_next
  assign run = !sd || os;
  assign after_cur = find_next(chan_r, chan_en);
  assign after_none = find_next(4'h0, chan_en);
  // pass starts local, or lowest enabled remote when local is off
  assign first_chan = chan_en[0] ? 4'h0 : after_none[3:0];
  assign last_chan = after_cur[4];
  assign next_chan = last_chan ? first_chan : after_cur[3:0];
  assign conv_end = state_r == tascr_pkg::ST_CONV
    && cnt_r == 32'(CONV_CYCLES - 1);
  assign pass_done = conv_end && last_chan;
  assign busy = state_r == tascr_pkg::ST_CONV;
  assign idle_ticks = IDLE_TICKS_MAX >> rate; // 16 s down to 0.25 s
  assign pass_gap = rate != tascr_pkg::CR_CONTINUOUS;
  assign res_if.store = conv_end;
  assign res_if.chan = chan_r;
  // state decode
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tascr_pkg::ST_IDLE: begin
        if (run && chan_en != 9'h000) begin
          state_nxt = tascr_pkg::ST_CONV;
        end
      end
      tascr_pkg::ST_CONV: begin
        if (!run) begin
          state_nxt = tascr_pkg::ST_IDLE;
        end else if (pass_done && (os || pass_gap)) begin
          state_nxt = os ? tascr_pkg::ST_IDLE : tascr_pkg::ST_WAIT;
        end
      end
      tascr_pkg::ST_WAIT: begin
        if (!run) begin
          state_nxt = tascr_pkg::ST_IDLE;
        end else if (tick_r == 32'(TICK_CYCLES - 1) && idle_r <= 7'h01) begin
          state_nxt = tascr_pkg::ST_CONV;
        end
      end
      default: begin
        state_nxt = tascr_pkg::ST_IDLE;
      end
    endcase
  end
  // counters and channel pointer
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= tascr_pkg::ST_IDLE;
      chan_r <= 4'h0;
      cnt_r <= 32'h0;
      tick_r <= 32'h0;
      idle_r <= 7'h00;
    end else begin
      state_r <= state_nxt;
      if (state_r != tascr_pkg::ST_CONV || state_nxt != tascr_pkg::ST_CONV
          || conv_end) begin
        cnt_r <= 32'h0;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
      if (state_r == tascr_pkg::ST_IDLE) begin
        chan_r <= first_chan;
      end else if (conv_end) begin
        chan_r <= next_chan;
      end
      if (state_r != tascr_pkg::ST_WAIT) begin
        tick_r <= 32'h0;
        idle_r <= idle_ticks;
      end else if (tick_r == 32'(TICK_CYCLES - 1)) begin
        tick_r <= 32'h0;
        idle_r <= idle_r - 7'h01;
      end else begin
        tick_r <= tick_r + 32'h1;
      end
    end
  end
  // ************************************************************
  // comparator and status read back
  // ************************************************************
  logic [8:0] lim2_flags;
  logic alert_r;
  tascr_cmp #(.TW(16)) tascr_cmp_inst (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .res(res_if),
    .temp_i(TEMP_I),
    .limit_i(LIMIT2_I),
    .hyst_i(HYST_I),
    .flags_o(lim2_flags)
  );
  // alert follows temperature flags only
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      alert_r <= 1'b1;
    end else begin
      alert_r <= ~|lim2_flags;
    end
  end
  // read mux
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 16'h0000;
    end else begin
      case (PTR_I)
        tascr_pkg::PTR_LIM2_STATUS: RDATA_O <= {lim2_flags[8:1],
          lim2_flags[0], 7'h00};
        tascr_pkg::PTR_OPEN_STATUS: RDATA_O <= {open_s2_r, 8'h00};
        tascr_pkg::PTR_CONFIG: RDATA_O <= cfg_r;
        default: RDATA_O <= 16'h0000;
      endcase
    end
  end
  assign CHAN_O = chan_r;
  assign RESULT_STORE_O = conv_end;
  assign SECOND_ALERT_PIN_O = alert_r;
endmodule : tascr_top
`default_nettype wire

// [tascr_pkg.sv]
package tascr_pkg;
  // ************************************************************
  // register pointers
  // ************************************************************
  localparam logic [7:0] PTR_LIM2_STATUS = 8'h22;
  localparam logic [7:0] PTR_OPEN_STATUS = 8'h23;
  localparam logic [7:0] PTR_CONFIG = 8'h30;
  // ************************************************************
  // configuration field layout and reset value
  // ************************************************************
  localparam int CFG_REN_LSB = 8;
  localparam int CFG_LEN_BIT = 7;
  localparam int CFG_OS_BIT = 6;
  localparam int CFG_SD_BIT = 5;
  localparam int CFG_CR_LSB = 2;
  localparam int CFG_BUSY_BIT = 1;
  localparam logic [15:0] CFG_RESET = 16'hFF9C; // all channels enabled
  localparam logic [15:0] CFG_WRITE_MASK = 16'hFFFC;
  localparam logic [2:0] CR_CONTINUOUS = 3'h7;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 125_000_000;
  localparam int CONV_US = 15800;
  localparam int CONV_CYC = CONV_US * (CLK_HZ / 1_000_000);
  localparam int TICK_MS = 250;
  localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_WAIT = 2'b10
  } tascr_state_e;
endpackage : tascr_pkg

// [tascr_if.sv]
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// result handoff from sequencer to comparator
// ************************************************************
interface tascr_if;
  logic store;
  logic [3:0] chan;
  modport src (output store, output chan);
  modport dst (input store, input chan);
endinterface : tascr_if
`default_nettype wire

// [tascr_cmp.sv]
`timescale 1ns/10ps
`default_nettype none
module tascr_cmp #(
  parameter int TW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tascr_if.dst res,
  input wire logic [TW-1:0] temp_i,
  input wire logic [TW-1:0] limit_i,
  input wire logic [TW-1:0] hyst_i,
  output logic [8:0] flags_o
);
  // ************************************************************
  // hysteresis compare, one channel per stored result
  // ************************************************************
  logic [8:0] flags_r;
  logic signed [TW:0] clr_lvl;
  logic over;
  logic under;
  assign clr_lvl = $signed({limit_i[TW-1], limit_i})
    - $signed({1'b0, hyst_i});
  assign over = $signed(temp_i) > $signed(limit_i);
  assign under = $signed({temp_i[TW-1], temp_i}) <= clr_lvl;
  assign flags_o = flags_r;
  // update on store only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_r <= 9'h000;
    end else if (res.store && res.chan < 4'h9) begin
      if (over) begin
        flags_r[res.chan] <= 1'b1;
      end else if (under) begin
        flags_r[res.chan] <= 1'b0;
      end
    end
  end
endmodule : tascr_cmp
`default_nettype wire

// [tascr_checker.sv]
`timescale 1ns/10ps
`default_nettype none
// ********
// port checker
// ********
module tascr_checker (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic WR_I,
  input wire logic [7:0] PTR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic [15:0] RDATA_O,
  input wire logic [15:0] TEMP_I,
  input wire logic [15:0] LIMIT2_I,
  input wire logic RESULT_STORE_O,
  input wire logic SECOND_ALERT_PIN_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // readback layout, store gap, shutdown and alert timing
  a_lim2_low_zero: assert property ($past(PTR_I) == 8'h22 |->
    RDATA_O[6:0] == 7'h00) else $error("limit status low bits set");
  a_open_low_zero: assert property ($past(PTR_I) == 8'h23 |->
    RDATA_O[7:0] == 8'h00) else $error("open status low bits set");
  a_cfg_write_back: assert property (WR_I && PTR_I == 8'h30 &&
    !WDATA_I[6] ##1 !WR_I && PTR_I == 8'h30 |=> {RDATA_O[15:7],
    RDATA_O[5:2]} == $past({WDATA_I[15:7], WDATA_I[5:2]}, 2))
    else $error("config readback wrong");
  a_store_gap: assert property (RESULT_STORE_O |=>
    !RESULT_STORE_O [*8]) else $error("conversion too short");
  a_alert_cause: assert property ($changed(SECOND_ALERT_PIN_O) |->
    $past(RESULT_STORE_O, 2)) else $error("alert moved without result");
  a_alert_sets: assert property (RESULT_STORE_O &&
    $signed(TEMP_I) > $signed(LIMIT2_I) |-> ##2 !SECOND_ALERT_PIN_O)
    else $error("alert not low on over limit");
  a_sd_abort: assert property (WR_I && PTR_I == 8'h30 &&
    WDATA_I[5] && !WDATA_I[6] |-> ##3 !RESULT_STORE_O [*8])
    else $error("conversion ran on in shutdown");
  a_busy_idle: assert property (($past(PTR_I) == 8'h30 &&
    RDATA_O[5] && !RDATA_O[6]) [*4] |-> !RDATA_O[1])
    else $error("busy set in shutdown");
  // main scenarios
  c_alert_low: cover property ($fell(SECOND_ALERT_PIN_O));
  c_alert_high: cover property ($rose(SECOND_ALERT_PIN_O));
  c_sd_write: cover property (WR_I && PTR_I == 8'h30 && WDATA_I[5]);
endmodule : tascr_checker
bind tascr_top tascr_checker tascr_checker_inst (.REF_CLK_I(REF_CLK_I),
  .RST_I(RST_I), .WR_I(WR_I), .PTR_I(PTR_I), .WDATA_I(WDATA_I),
  .RDATA_O(RDATA_O), .TEMP_I(TEMP_I), .LIMIT2_I(LIMIT2_I),
  .RESULT_STORE_O(RESULT_STORE_O), .SECOND_ALERT_PIN_O(SECOND_ALERT_PIN_O));
`default_nettype wire

// [tascr_host.sv]
`timescale 1ns/10ps
`default_nettype none
// ********
// host register access model
// ********
module tascr_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic wr_o,
  output logic [7:0] ptr_o,
  output logic [15:0] wdata_o,
  output logic stb_o,
  output logic [15:0] data_o
);
  // bus idle from time zero
  initial begin
    wr_o = 1'b0;
    ptr_o = 8'h00;
    wdata_o = 16'h0000;
    stb_o = 1'b0;
  end
  // one write, data scrambled once taken
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    ptr_o = p;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : wr
  // pointer first, registered data a cycle later
  task automatic rd(input logic [7:0] p);
    @(negedge clk_i);
    ptr_o = p;
    @(negedge clk_i);
    data_o = rdata_i;
    stb_o = 1'b1;
    @(negedge clk_i);
    stb_o = 1'b0;
  endtask : rd
endmodule : tascr_host
`default_nettype wire

// [tascr_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module tascr_bench;
  logic clk, rst, wr, stb, st, alert;
  logic [15:0] t [0:8];
  logic [15:0] temp, wd, rdat, rd_v;
  logic [15:0] expq [$];
  logic [7:0] open, ptr;
  logic [3:0] ch;
  logic [31:0] seed;
  int n_fail;
  int total_checks;
  tascr_host tascr_host_inst (.clk_i(clk), .rdata_i(rdat), .wr_o(wr),
    .ptr_o(ptr), .wdata_o(wd), .stb_o(stb), .data_o(rd_v));
  tascr_top #(.CONV_CYCLES(20), .TICK_CYCLES(10)) tascr_top_inst (
    .REF_CLK_I(clk), .RST_I(rst), .WR_I(wr), .PTR_I(ptr), .WDATA_I(wd),
    .RDATA_O(rdat), .TEMP_I(temp), .LIMIT2_I(16'h0064),
    .HYST_I(16'h000A), .OPEN_DET_I(open), .CHAN_O(ch),
    .RESULT_STORE_O(st), .SECOND_ALERT_PIN_O(alert));
  // ********
  // clock, converter results, helpers
  // ********
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) temp <= t[ch];
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic check(input logic [15:0] seen, input logic [15:0] ex,
      input string what);
    total_checks++;
    if (seen !== ex) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, ex, seen);
    end
  endtask : check
  task automatic rdx(input logic [7:0] p, input logic [15:0] v);
    expq.push_back(v);
    tascr_host_inst.rd(p);
  endtask : rdx
  task automatic wait_ch(input logic [3:0] c);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(st === 1'b1 && ch === c) && n < 400);
    if (n >= 400) n_fail++;
    repeat (3) @(negedge clk);
  endtask : wait_ch
  task automatic pass2;
    wait_ch(4'h4);
    wait_ch(4'h4);
  endtask : pass2
  task automatic cnt(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (st === 1'b1) k++;
    end
  endtask : cnt
  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  // read results against oldest expectation
  always @(posedge clk) begin
    if (stb === 1'b1) check(rd_v, expq.pop_front(), "rdata");
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  // main sequence
  initial begin
    int k;
    rst = 1'b1;
    open = 8'h00;
    temp = 16'h0000;
    seed = 32'h5C6B2794;
    n_fail = 0;
    total_checks = 0;
    for (int i = 0; i < 9; i++) begin
      seed = xs(seed);
      t[i] = {10'h000, seed[5:0]};
    end
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk); // busy bit sets on the second edge after reset release
    rdx(8'h30, tascr_pkg::CFG_RESET | 16'h0002);
    rdx(8'h22, 16'h0000);
    open = seed[15:8];
    repeat (4) @(negedge clk);
    rdx(8'h23, {open, 8'h00});
    tascr_host_inst.wr(8'h22, 16'hFFFF);
    tascr_host_inst.wr(8'h23, 16'hFFFF);
    rdx(8'h22, 16'h0000);
    check({15'h0000, alert}, 16'h0001, "alert");
    t[0] = 16'h0065;
    t[3] = 16'h0065;
    pass2();
    rdx(8'h22, 16'h0480);
    check({15'h0000, alert}, 16'h0000, "alert");
    t[0] = 16'h005A;
    t[3] = 16'h005F;
    pass2();
    rdx(8'h22, 16'h0400);
    t[3] = 16'h005A;
    pass2();
    rdx(8'h22, 16'h0000);
    check({15'h0000, alert}, 16'h0001, "alert");
    tascr_host_inst.wr(8'h30, tascr_pkg::CFG_RESET | 16'h0020);
    repeat (3) @(negedge clk);
    cnt(60, k);
    check(16'(k), 16'h0000, "stores");
    for (int r = 0; r < 8; r++) begin
      tascr_host_inst.wr(8'h30, 16'h0FA0 | 16'(r << 2));
      rdx(8'h30, 16'h0FA0 | 16'(r << 2));
    end
    tascr_host_inst.wr(8'h30, 16'h01FC);
    cnt(150, k);
    check(16'(k), 16'h0002, "stores");
    rdx(8'h30, 16'h01BC);
    tascr_host_inst.wr(8'h30, 16'h017C);
    cnt(150, k);
    check(16'(k), 16'h0001, "stores");
    // running at one pass per tick: gap is one tick plus one conversion
    tascr_host_inst.wr(8'h30, 16'h0198);
    wait_ch(4'h1);
    cnt(26, k);
    check(16'(k), 16'h0000, "idle stores");
    cnt(3, k);
    check(16'(k), 16'h0001, "idle stores");
    complete_run();
  end
endmodule : tascr_bench
`default_nettype wire
